//--- verilog/eeprom_device.sv
// Operation
// R1: command opens with eight-bit address word, msb first
// R2: upper four bits must equal 1010
// R3: three select bits match pins, else standby
// R4: last bit zero writes, one reads
// R5: byte write acks on clocks 9,18,27
// R6: after write stop, self-timed programming, inputs ignored
// R7: page write takes one to sixteen bytes
// R8: only low four column bits increment
// R9: beyond sixteen bytes the column wraps
// R10: no address ack while programming
// R11: counter holds last address plus one
// R12: current read: ack, byte out, no ack, stop
// R13: host ack asks for next byte
// R14: counter wraps past top address
// R15: random read is dummy write then read
// R16: start after word address abandons pending write
// R17: sample on rising, drive after falling edge
// R18: ack drives data low on ninth clock
// R19: sixteen pages of sixteen bytes
// R20: write protect high blocks programming
// R21: programming time is a parameter
`timescale 1ns/1ns
`include "eeprom_cfg.svh"
module eeprom_device
#(
  parameter int PROG_CYCLES = `PROG_CYCLES
)
(
  input  wire logic clk,
  input  wire logic reset_n,
  twi_if.device     bus,
  input  wire logic chip_select_bit_2,
  input  wire logic chip_select_bit_1,
  input  wire logic chip_select_bit_0,
  input  wire logic write_protect,
  output logic      busy
);
  import eeprom_pkg::*;

  typedef enum {ST_IDLE, ST_DEVADDR, ST_WORDADDR, ST_WDATA, ST_RDATA, ST_PROG} dev_state_t;

  wire  [7:0]  col_rd [16];
  wire  [3:0]  pin_raw = {write_protect, chip_select_bit_2, chip_select_bit_1, chip_select_bit_0};
  wire  [3:0]  pin_s;
  logic [7:0]  page_buf [16];
  logic [15:0] page_dirty_r;
  logic        scl_s, sda_s, scl_d_r, sda_d_r;
  dev_state_t  state_r;
  logic [3:0]  bit_r;
  logic [7:0]  shift_r;
  logic [7:0]  addr_r;
  logic [7:0]  tx_r;
  logic        ack_phase_r;
  logic        ack_ok_r;
  logic [31:0] prog_cnt_r;

  pin_sync u_scl (.clk(clk), .reset_n(reset_n), .pin(bus.scl), .level(scl_s));
  pin_sync u_sda (.clk(clk), .reset_n(reset_n), .pin(bus.sda), .level(sda_s));

  generate
    for (genvar p = 0; p < 4; p++)
    begin : g_pin
      pin_sync u_pin (.clk(clk), .reset_n(reset_n), .pin(pin_raw[p]), .level(pin_s[p]));
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire rise   = scl_s & ~scl_d_r;
  wire fall   = ~scl_s & scl_d_r;
  wire start  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire [7:0] rx_byte = {shift_r[6:0], sda_s};
  wire sel_ok = rx_byte[7:4] == `DEV_CLASS &&
                rx_byte[3:1] == pin_s[2:0]; // R2 R3

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r      <= ST_IDLE;
      bit_r        <= 4'h0;
      shift_r      <= 8'h00;
      addr_r       <= 8'h00;
      ack_phase_r  <= 1'b0;
      ack_ok_r     <= 1'b0;
      page_dirty_r <= 16'h0000;
      prog_cnt_r   <= 32'h0;
    end
    else if (state_r == ST_PROG)
    begin
      if (prog_cnt_r >= 32'(PROG_CYCLES - 1)) // R6 R21
      begin
        state_r      <= ST_IDLE;
        page_dirty_r <= 16'h0000;
      end
      prog_cnt_r <= prog_cnt_r + 32'h1;
    end
    else if (start)
    begin
      state_r      <= ST_DEVADDR; // R1 R16
      bit_r        <= 4'h0;
      ack_phase_r  <= 1'b0;
      page_dirty_r <= 16'h0000;
    end
    else if (stop)
    begin
      if (state_r == ST_WDATA && page_dirty_r != 16'h0000 && !pin_s[3]) // R6 R20
      begin
        state_r    <= ST_PROG;
        prog_cnt_r <= 32'h0;
      end
      else
      begin
        state_r      <= ST_IDLE;
        page_dirty_r <= 16'h0000;
      end
    end
    else if (rise && state_r != ST_IDLE)
    begin
      if (ack_phase_r)
      begin
        ack_phase_r <= 1'b0;
        bit_r       <= 4'h0;
        if (state_r == ST_RDATA && sda_s) // R12
          state_r <= ST_IDLE;
      end
      else
      begin
        shift_r <= rx_byte; // R1 R17
        bit_r   <= bit_r + 4'h1;
        if (bit_r == 4'h7)
        begin
          ack_phase_r <= 1'b1;
          ack_ok_r    <= 1'b1;
          unique case (state_r)
            ST_DEVADDR:
              if (!sel_ok)
              begin
                state_r  <= ST_IDLE; // R3
                ack_ok_r <= 1'b0;
              end
              else if (rx_byte[0]) // R4
                state_r  <= ST_RDATA;
              else
                state_r <= ST_WORDADDR;
            ST_WORDADDR:
            begin
              addr_r  <= rx_byte; // R15 R19
              state_r <= ST_WDATA;
            end
            ST_WDATA:
            begin
              page_buf[addr_r[3:0]]     <= rx_byte; // R7 R9
              page_dirty_r[addr_r[3:0]] <= 1'b1;
              addr_r <= {addr_r[7:4], addr_r[3:0] + 4'h1}; // R8
            end
            ST_RDATA:
            begin
              ack_ok_r <= 1'b0;
              addr_r   <= addr_r + 8'h01; // R11 R13 R14
            end
            default:
              state_r <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // first read byte is fetched from the address counter before it advances
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tx_r <= 8'h00;
    else if (state_r == ST_DEVADDR)
      tx_r <= col_rd[addr_r[3:0]]; // R12
    else if (state_r == ST_RDATA && ack_phase_r && rise && !sda_s)
      tx_r <= col_rd[addr_r[3:0]]; // R13
    else if (state_r == ST_RDATA && fall && !ack_phase_r && bit_r != 4'h0)
      tx_r <= {tx_r[6:0], 1'b0};
  end

  generate
    for (genvar i = 0; i < 16; i++)
    begin : g_prog
      logic [7:0] col_mem [`ARRAY_DEPTH / 16];
      always_ff @(posedge clk)
        if (state_r == ST_PROG && prog_cnt_r == 32'h0 && page_dirty_r[i])
          col_mem[addr_r[7:4]] <= page_buf[i]; // R19
      assign col_rd[i] = col_mem[addr_r[7:4]];
    end
  endgenerate

  // open-drain data drive changes only after the falling clock edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus.sda_dev_oe <= 1'b0;
      bus.sda_dev_o  <= 1'b0;
    end
    else if (start || stop || state_r == ST_IDLE || state_r == ST_PROG) // R10
      bus.sda_dev_oe <= 1'b0;
    else if (fall)
    begin
      if (ack_phase_r)
        bus.sda_dev_oe <= ack_ok_r; // R18 R5
      else if (state_r == ST_RDATA)
        bus.sda_dev_oe <= (bit_r == 4'h0) ? ~tx_r[7] : ~tx_r[6]; // R17
      else
        bus.sda_dev_oe <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      busy <= 1'b0;
    else
      busy <= state_r == ST_PROG;
  end
endmodule // eeprom_device

//--- common/eeprom_cfg.svh
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH
`define DEV_CLASS          4'hA
`define CLK_PERIOD_NS      10
`define PROG_TIME_NS       5000000
`define PROG_CYCLES        (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define SCL_HALF_DIV       8
`define ARRAY_DEPTH        256
`define COL_BITS           4
`endif

//--- common/eeprom_pkg.sv
package eeprom_pkg;
  typedef enum logic [1:0] {CMD_WRITE, CMD_READ_CUR, CMD_ADDR_ONLY} host_cmd_t;
  typedef logic [7:0] byte_t;
endpackage

//--- common/twi_if.sv
`timescale 1ns/1ns
interface twi_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  wire  scl = scl_oe ? scl_o : 1'b1;
  wire  sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);
  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (input sda, output scl_o, output scl_oe, output sda_host_o, output sda_host_oe);
endinterface

//--- verilog/pin_sync.sv
`timescale 1ns/1ns
module pin_sync
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      level
);
  logic [2:0] s_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s_r <= 3'h7;
    else
      s_r <= {s_r[1:0], pin};
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      level <= 1'b1;
    else if (s_r[1] == s_r[2])
      level <= s_r[2];
  end
endmodule // pin_sync

//--- verilog/eeprom_host.sv
`timescale 1ns/1ns
`include "eeprom_cfg.svh"
module eeprom_host
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  twi_if.host                      bus,
  input  wire logic                req,
  input  eeprom_pkg::host_cmd_t    cmd,
  input  wire logic [2:0]          dev_sel,
  input  wire logic [7:0]          word_addr,
  input  wire logic [7:0]          wdata,
  input  wire logic [4:0]          nbytes,
  output logic                     busy,
  output logic                     done,
  output logic                     nack,
  output logic [7:0]               rdata,
  output logic                     rvalid
);
  import eeprom_pkg::*;

  typedef enum {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;

  host_state_t state_r;
  host_cmd_t   cmd_r;
  logic [3:0]  div_r;
  logic [1:0]  ph_r;
  logic [3:0]  bit_r;
  logic [1:0]  stage_r;
  logic [4:0]  left_r;
  logic [7:0]  sh_r;
  logic        sda_in;

  pin_sync u_sda (.clk(clk), .reset_n(reset_n), .pin(bus.sda), .level(sda_in));

  wire tick = div_r == 4'(`SCL_HALF_DIV - 1);
  wire reading = cmd_r == CMD_READ_CUR && stage_r == 2'h1;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      div_r <= 4'h0;
    else
      div_r <= tick ? 4'h0 : div_r + 4'h1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= H_IDLE; cmd_r <= CMD_WRITE; ph_r <= 2'h0; bit_r <= 4'h0;
      stage_r <= 2'h0; left_r <= 5'h0; sh_r <= 8'h00;
      bus.scl_o <= 1'b1; bus.scl_oe <= 1'b0; bus.sda_host_o <= 1'b0; bus.sda_host_oe <= 1'b0;
      busy <= 1'b0; done <= 1'b0; nack <= 1'b0; rdata <= 8'h00; rvalid <= 1'b0;
    end
    else
    begin
      done   <= 1'b0;
      rvalid <= 1'b0;
      unique case (state_r)
        H_IDLE:
          if (req)
          begin
            cmd_r <= cmd; left_r <= nbytes; busy <= 1'b1; nack <= 1'b0;
            sh_r <= {`DEV_CLASS, dev_sel, cmd == CMD_READ_CUR}; // R1 R4
            stage_r <= 2'h0; ph_r <= 2'h0; bit_r <= 4'h0;
            state_r <= H_START;
          end
        H_START:
          if (tick)
          begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h0) bus.sda_host_oe <= 1'b1;
            if (ph_r == 2'h1)
            begin
              bus.scl_oe <= 1'b1; bus.scl_o <= 1'b0; ph_r <= 2'h0; state_r <= H_BIT;
            end
          end
        H_BIT:
          if (tick)
          begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h0)
            begin
              if (bit_r < 4'h8)
                bus.sda_host_oe <= reading ? 1'b0 : ~sh_r[7];
              else
                bus.sda_host_oe <= reading && left_r > 5'h1; // R13 R12
            end
            else if (ph_r == 2'h1)
              bus.scl_o <= 1'b1;
            else if (ph_r == 2'h2)
            begin
              if (bit_r < 4'h8)
                sh_r <= {sh_r[6:0], sda_in};
              else if (!reading && sda_in)
                nack <= 1'b1;
            end
            else
            begin
              bus.scl_o <= 1'b0; ph_r <= 2'h0;
              bit_r <= bit_r == 4'h8 ? 4'h0 : bit_r + 4'h1;
              if (bit_r == 4'h8)
              begin
                if (reading) begin rdata <= sh_r; rvalid <= 1'b1; end
                if (nack || (!reading && sda_in)) state_r <= H_STOP;
                else if (stage_r == 2'h0 && cmd_r == CMD_READ_CUR) stage_r <= 2'h1;
                else if (stage_r == 2'h0) begin stage_r <= 2'h2; sh_r <= word_addr; end // R5 R15
                else if (reading || cmd_r == CMD_ADDR_ONLY) state_r <= reading && left_r > 5'h1 ? H_BIT : H_STOP;
                else if (left_r == 5'h0 || (stage_r == 2'h3 && left_r == 5'h1)) state_r <= H_STOP;
                else sh_r <= wdata; // R7
                if (stage_r != 2'h0 && (reading || stage_r == 2'h3)) left_r <= left_r - 5'h1;
                if (stage_r == 2'h2) stage_r <= 2'h3;
              end
            end
          end
        H_STOP:
          if (tick)
          begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h0) bus.sda_host_oe <= 1'b1;
            if (ph_r == 2'h1) bus.scl_oe <= 1'b0;
            if (ph_r == 2'h2)
            begin
              bus.sda_host_oe <= 1'b0; busy <= 1'b0; done <= 1'b1; state_r <= H_IDLE;
            end
          end
        default:
          state_r <= H_IDLE;
      endcase
    end
  end
endmodule // eeprom_host

//--- dv/eeprom_chk.sv
`timescale 1ns/1ns
module eeprom_chk
#(
  parameter int PROG_CYCLES = 1000
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic busy
);
  logic       scl_r;
  logic       sda_r;
  logic [3:0] bit_r;
  logic [7:0] byte_r;
  logic [7:0] addr_r;
  int         prog_r;
  wire        start = scl && scl_r && sda_r && !sda;
  wire        rise  = scl && !scl_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // bus history
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end
    else
    begin
      scl_r <= scl;
      sda_r <= sda;
    end
  end
  // bit and byte position since start
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_r  <= 4'h0;
      byte_r <= 8'h00;
    end
    else if (start)
    begin
      bit_r  <= 4'h0;
      byte_r <= 8'h00;
    end
    else if (rise)
    begin
      bit_r  <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
      byte_r <= (bit_r == 4'h8) ? byte_r + 8'h01 : byte_r;
    end
  end
  // address word capture
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      addr_r <= 8'h00;
    else if (rise && byte_r == 8'h00 && bit_r != 4'h8)
      addr_r <= {addr_r[6:0], sda};
  end
  // programming length
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prog_r <= 0;
    else
      prog_r <= busy ? prog_r + 1 : 0;
  end
  sequence s_ninth;
    rise && bit_r == 4'h8;
  endsequence
  sequence s_idle;
    scl && sda;
  endsequence
  a_write_quiet: assert property (
    rise && bit_r != 4'h8 && (byte_r == 8'h00 || !addr_r[0]) |-> !sda_dev_oe)
    else $error("device drove data outside ack slot");
  a_class_match: assert property (
    s_ninth ##0 (byte_r == 8'h00 && sda_dev_oe) |-> addr_r[7:4] == 4'hA)
    else $error("ack given to foreign class");
  a_host_ack_free: assert property (
    s_ninth ##0 (byte_r != 8'h00 && addr_r[0]) |-> !sda_dev_oe)
    else $error("device held host ack slot");
  a_ack_low: assert property (
    rise && sda_dev_oe |-> !sda)
    else $error("driven data line not low");
  a_drive_low: assert property (
    sda_dev_oe |-> !sda_dev_o)
    else $error("device drove data line high");
  a_high_stable: assert property (
    rise |=> $stable(sda_dev_oe) [*4])
    else $error("device output moved with clock high");
  a_change_low: assert property (
    !$stable(sda_dev_oe) |-> !scl)
    else $error("device output moved while clock high");
  a_busy_quiet: assert property (
    busy |-> !sda_dev_oe)
    else $error("device answered while programming");
  a_busy_stop: assert property (
    $rose(busy) |-> s_idle)
    else $error("programming began on a busy bus");
  a_prog_time: assert property (
    $fell(busy) |-> prog_r >= PROG_CYCLES - 8 && prog_r <= PROG_CYCLES + 8)
    else $error("programming time off");
endmodule // eeprom_chk

//--- dv/serial_eeprom_command_engine_tb.sv
`timescale 1ns/1ns
module serial_eeprom_command_engine_tb;
  import eeprom_pkg::*;
  localparam int PROG = 1000;
  logic       clk = 1'h0;
  logic       reset_n = 1'h0;
  logic       req = 1'h0;
  host_cmd_t  cmd = CMD_WRITE;
  logic [2:0] cs = 3'h0;
  logic [2:0] sel = 3'h0;
  logic [7:0] wa = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [4:0] nb = 5'h00;
  logic       wp = 1'h0;
  logic       h_busy;
  logic       d_busy;
  logic       done;
  logic       nack;
  logic       rvalid;
  logic [7:0] rdata;
  byte_t      mem [256];
  byte_t      rq [$];
  byte_t      lf = 8'h4E;
  byte_t      a;
  int         i;
  int         cyc = 0;
  int         miscompares = 0;
  int         comparisons = 0;
  twi_if bus ();
  eeprom_device #(.PROG_CYCLES(PROG)) u_eeprom_device (.clk(clk), .reset_n(reset_n), .bus(bus),
    .chip_select_bit_2(cs[2]), .chip_select_bit_1(cs[1]), .chip_select_bit_0(cs[0]),
    .write_protect(wp), .busy(d_busy));
  eeprom_host u_eeprom_host (.clk(clk), .reset_n(reset_n), .bus(bus), .req(req), .cmd(cmd),
    .dev_sel(sel), .word_addr(wa), .wdata(wd), .nbytes(nb), .busy(h_busy), .done(done),
    .nack(nack), .rdata(rdata), .rvalid(rvalid));
  eeprom_chk #(.PROG_CYCLES(PROG)) u_eeprom_chk (.clk(clk), .reset_n(reset_n), .scl(bus.scl),
    .sda(bus.sda), .sda_dev_o(bus.sda_dev_o), .sda_dev_oe(bus.sda_dev_oe), .busy(d_busy));
  always #5 clk = ~clk;
  always @(posedge clk)
    if (rvalid === 1'h1)
      rq.push_back(rdata);
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      miscompares++;
      summarize();
    end
  end
  function automatic byte_t rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp || $isunknown(seen))
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic run(host_cmd_t c, logic [2:0] s, logic [7:0] ad, logic [7:0] d, logic [4:0] n);
    int k;
    k = 0;
    @(posedge clk);
    #1;
    cmd = c;
    sel = s;
    wa = ad;
    wd = d;
    nb = n;
    req = 1'h1;
    rq.delete();
    @(posedge clk);
    #1;
    req = 1'h0;
    while (done !== 1'h1 && k < 9000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("done", done, 1'h1);
    chk("host_idle", h_busy, 1'h0);
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] d, logic [4:0] n);
    int k;
    run(CMD_WRITE, cs, ad, d, n);
    if (!wp)
      chk("write_ack", nack, 1'h0);
    for (k = 0; k < n; k++)
      if (!wp)
        mem[{ad[7:4], ad[3:0] + k[3:0]}] = d;
    k = 0;
    run(CMD_ADDR_ONLY, cs, 8'h00, 8'h00, 5'h00);
    if (!wp)
      chk("poll_nack", nack, 1'h1);
    while (nack !== 1'h0 && k < 8)
    begin
      run(CMD_ADDR_ONLY, cs, 8'h00, 8'h00, 5'h00);
      k++;
    end
    chk("poll_ack", nack, 1'h0);
  endtask
  task automatic rd(logic [7:0] ad, logic [4:0] n);
    int k;
    run(CMD_ADDR_ONLY, cs, ad, 8'h00, 5'h00);
    repeat (8) @(posedge clk);
    chk("dummy_busy", d_busy, 1'h0);
    run(CMD_READ_CUR, cs, 8'h00, 8'h00, n);
    chk("read_ack", nack, 1'h0);
    chk("read_count", rq.size(), n);
    for (k = 0; k < n; k++)
      chk("read_data", rq[k], mem[ad + k[7:0]]);
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'h1;
    a = rnd();
    cs = a[2:0];
    for (i = 0; i < 3; i++)
    begin
      a = rnd();
      wr(a, rnd(), 5'h01);
      rd(a, 5'h01);
    end
    $display("test byte_write done");
    wr(8'hF0, 8'hA5, 5'h10);
    wr(8'h00, 8'h5A, 5'h10);
    rd(8'hFE, 5'h04);
    run(CMD_READ_CUR, cs, 8'h00, 8'h00, 5'h01);
    chk("cur_addr", rq[0], mem[8'h02]);
    $display("test sequential_wrap done");
    wr(8'h20, rnd(), 5'h10);
    wr(8'h1E, rnd(), 5'h12);
    rd(8'h1E, 5'h04);
    rd(8'h10, 5'h01);
    $display("test page_roll done");
    wp = 1'h1;
    wr(8'h05, 8'h3C, 5'h01);
    wp = 1'h0;
    run(CMD_READ_CUR, ~cs, 8'h00, 8'h00, 5'h01);
    chk("select_nack", nack, 1'h1);
    rd(8'h05, 5'h01);
    $display("test protect_select done");
    summarize();
  end
endmodule // serial_eeprom_command_engine_tb
